// file: hdl/ebm_pkg.sv
/*
 * package of the expansion bus master: widths, chip-select modes, pin bundle,
 * request bundle and cycle states.
 * assumes nothing of its surroundings; imported whole by the master module.
 */
package ebm_pkg;

	// ----------------------------------------------------------------
	// widths and counts
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W       = 24;
	localparam int unsigned DATA_W       = 16;
	localparam int unsigned CS_NUM       = 8;
	localparam int unsigned CS_SEL_W     = 3;
	localparam int unsigned RDY_NUM      = 4;
	localparam int unsigned HOST_CS_BASE = 4;  // first chip select that may run host-port cycles
	localparam int unsigned SETTLE_W     = 2;
	localparam logic [1:0]  STRAP_SETTLE = 2'h3; // cycles to fill the strap synchroniser

	// ----------------------------------------------------------------
	// chip-select cycle modes
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		EBM_MODE_SEP  = 2'h0, // separate read and write strobes
		EBM_MODE_DS   = 2'h1, // data strobe plus read-not-write
		EBM_MODE_HOST = 2'h2  // host-port mode, ready paced
	} ebm_mode_e;

	// ----------------------------------------------------------------
	// bus cycle states, gray along idle-addr-strobe-end
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		EBM_ST_IDLE = 2'h0,
		EBM_ST_ADDR = 2'h1,
		EBM_ST_STRB = 2'h3,
		EBM_ST_END  = 2'h2
	} ebm_state_e;

	// ----------------------------------------------------------------
	// bundles
	// ----------------------------------------------------------------
	typedef struct packed {
		logic                 write;
		logic [CS_SEL_W-1:0]  cs;
		logic [ADDR_W-1:0]    addr;
		logic [DATA_W-1:0]    wdata;
	} ebm_req_s;

	typedef struct packed {
		logic                 address_latch_strobe;
		logic [ADDR_W-1:0]    bus_address;
		logic                 bus_address_oe;
		logic                 write_strobe_n;
		logic                 read_strobe_n;
		logic [CS_NUM-1:0]    chip_select_n;
		logic [DATA_W-1:0]    bus_data;
		logic                 bus_data_oe;
	} ebm_pins_s;

	localparam ebm_pins_s PINS_IDLE = '{
		address_latch_strobe: 1'b0,
		bus_address:          '0,
		bus_address_oe:       1'b0,
		write_strobe_n:       1'b1,
		read_strobe_n:        1'b1,
		chip_select_n:        '1,
		bus_data:             '0,
		bus_data_oe:          1'b0
	};

endpackage

// file: hdl/ebm_master.sv
/*
 * expansion bus master: runs multiplexed bus cycles on eight chip selects,
 * paced by an external bus clock that is sampled on the core clock.
 * assumes a core clock well above twice the bus clock; the testbench resolves
 * the two-way address and data wires from the enables.
 */
// Summary of operation
// - bus pins other than the address enable move only on bus clock edges
// - pulse address latch strobe in address phase
// - drive access address on 24-bit address bus
// - sample address lines as straps after reset release
// - write pin: write, data or host strobe
// - read pin: read strobe or read-not-write
// - eight chip selects, each sep or ds
// - host mode only on chip selects four-seven
// - wait low halts access, resumes when high
// - wait ignored in host-port mode
// - ready polarity selectable per input
// - host access halts while its ready inactive
// - ready inputs ignored for chip selects 0-3
module ebm_master
	import ebm_pkg::*;
(
	input  wire logic                   clk_i,            // core clock, 200 MHz
	input  wire logic                   rst_b_i,          // async reset, active low
	input  wire logic                   bus_clock_in_i,   // external bus clock
	input  wire logic                   wait_in_n_i,      // wait from peripherals, low halts
	input  wire logic [RDY_NUM-1:0]     host_port_ready_i,// ready per chip select 4..7
	input  wire logic [ADDR_W-1:0]      bus_address_i,    // address wires as seen at the pins
	input  wire logic [DATA_W-1:0]      bus_data_i,       // data wires as seen at the pins
	input  wire logic [2*CS_NUM-1:0]    cs_mode_i,        // two mode bits per chip select
	input  wire logic [RDY_NUM-1:0]     ready_high_i,     // 1: ready input active high
	input  wire logic                   req_valid_i,      // access request
	input  wire ebm_req_s               req_i,            // access direction, target, data
	output logic                        req_ready_o,      // request taken when high with valid
	output logic                        rsp_valid_o,      // one-cycle pulse, access finished
	output logic [DATA_W-1:0]           rsp_rdata_o,      // read data, held until next read
	output logic [ADDR_W-1:0]           straps_o,         // address lines caught after reset release
	output logic                        straps_valid_o,   // straps captured, bus usable
	output ebm_pins_s                   pins_o            // all driven bus pins and enables
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// effective mode of a chip select; host mode falls back below cs 4
	function automatic ebm_mode_e eff_mode(input logic [CS_SEL_W-1:0] cs,
	                                       input logic [2*CS_NUM-1:0] modes);
		logic [1:0] m;
		m = modes[2*cs +: 2];
		if (m == EBM_MODE_HOST && cs >= CS_SEL_W'(HOST_CS_BASE)) begin
			return EBM_MODE_HOST;
		end else if (m == EBM_MODE_DS) begin
			return EBM_MODE_DS;
		end else begin
			return EBM_MODE_SEP;
		end
	endfunction

	// ----------------------------------------------------------------
	// synchronisers: two flops before any logic looks at a pin
	// ----------------------------------------------------------------
	logic                 bclk_m_q, bclk_s_q, bclk_p_q;
	logic                 wait_m_q, wait_s_q;
	logic [RDY_NUM-1:0]   rdy_m_q, rdy_s_q;
	logic [ADDR_W-1:0]    addr_m_q, addr_s_q;
	logic [DATA_W-1:0]    data_m_q, data_s_q;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			bclk_m_q <= 1'b0;
			bclk_s_q <= 1'b0;
			bclk_p_q <= 1'b0;
			wait_m_q <= 1'b1;
			wait_s_q <= 1'b1;
			rdy_m_q  <= '0;
			rdy_s_q  <= '0;
			addr_m_q <= '1;
			addr_s_q <= '1;
			data_m_q <= '0;
			data_s_q <= '0;
		end else begin
			bclk_m_q <= bus_clock_in_i;
			bclk_s_q <= bclk_m_q;
			bclk_p_q <= bclk_s_q;
			wait_m_q <= wait_in_n_i;
			wait_s_q <= wait_m_q;
			rdy_m_q  <= host_port_ready_i;
			rdy_s_q  <= rdy_m_q;
			addr_m_q <= bus_address_i;
			addr_s_q <= addr_m_q;
			data_m_q <= bus_data_i;
			data_s_q <= data_m_q;
		end
	end

	// rising edge of the bus clock; all pin changes but the address enable at strap capture wait for it
	logic bedge;
	assign bedge = bclk_s_q & ~bclk_p_q;

	// ----------------------------------------------------------------
	// strap capture after reset release
	// ----------------------------------------------------------------
	logic [SETTLE_W-1:0] settle_q, settle_d;
	logic [ADDR_W-1:0]   straps_q, straps_d;
	logic                strap_done_q, strap_done_d;

	// address pins are released while settling, pull-ups and board set the level
	always_comb begin
		settle_d     = settle_q;
		straps_d     = straps_q;
		strap_done_d = strap_done_q;
		if (!strap_done_q) begin
			straps_d = addr_s_q;
			if (settle_q == STRAP_SETTLE) begin
				strap_done_d = 1'b1;
			end else begin
				settle_d = settle_q + SETTLE_W'(1);
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			settle_q     <= '0;
			straps_q     <= '1;
			strap_done_q <= 1'b0;
		end else begin
			settle_q     <= settle_d;
			straps_q     <= straps_d;
			strap_done_q <= strap_done_d;
		end
	end

	assign straps_o       = straps_q;
	assign straps_valid_o = strap_done_q;

	// ----------------------------------------------------------------
	// bus cycle engine
	// ----------------------------------------------------------------
	ebm_state_e           state_q, state_d;
	ebm_req_s             cur_q, cur_d;
	ebm_mode_e            mode_q, mode_d;
	logic                 pend_q, pend_d;
	logic                 rdy_q, rdy_d;
	logic                 rsp_q, rsp_d;
	logic [DATA_W-1:0]    rdata_q, rdata_d;
	ebm_pins_s            pins_q, pins_d;
	logic                 stall;
	logic [CS_SEL_W-1:0]  rdy_idx;
	logic                 rdy_active;

	// stall source follows the mode of the running access
	always_comb begin
		rdy_idx    = cur_q.cs - CS_SEL_W'(HOST_CS_BASE);
		rdy_active = ~(rdy_s_q[rdy_idx[1:0]] ^ ready_high_i[rdy_idx[1:0]]);
		if (mode_q == EBM_MODE_HOST) begin
			stall = ~rdy_active;
		end else begin
			stall = ~wait_s_q;
		end
	end

	always_comb begin
		state_d = state_q;
		cur_d   = cur_q;
		mode_d  = mode_q;
		pend_d  = pend_q;
		rdy_d   = rdy_q;
		rsp_d   = 1'b0;
		rdata_d = rdata_q;
		pins_d  = pins_q;
		if (strap_done_q) begin
			pins_d.bus_address_oe = 1'b1; // straps taken, address becomes an output
		end
		// request hand-off, independent of bus clock
		if (req_valid_i && rdy_q) begin
			cur_d  = req_i;
			mode_d = eff_mode(req_i.cs, cs_mode_i);
			pend_d = 1'b1;
			rdy_d  = 1'b0;
		end
		if (bedge) begin
			case (state_q)
				EBM_ST_IDLE: begin
					if (pend_q) begin
						pend_d = 1'b0;
						state_d = EBM_ST_ADDR;
						pins_d.address_latch_strobe = 1'b1;
						pins_d.bus_address = cur_q.addr;
						pins_d.bus_data = cur_q.addr[DATA_W-1:0];
						pins_d.bus_data_oe = 1'b1;
						pins_d.chip_select_n = ~(CS_NUM'(1) << cur_q.cs);
						pins_d.read_strobe_n = (mode_q == EBM_MODE_SEP) ? 1'b1 : ~cur_q.write;
					end
				end
				EBM_ST_ADDR: begin
					state_d = EBM_ST_STRB;
					pins_d.address_latch_strobe = 1'b0;
					pins_d.bus_data = cur_q.wdata;
					pins_d.bus_data_oe = cur_q.write;
					if (mode_q == EBM_MODE_SEP) begin
						pins_d.write_strobe_n = ~cur_q.write;
						pins_d.read_strobe_n  = cur_q.write;
					end else begin
						pins_d.write_strobe_n = 1'b0;
					end
				end
				EBM_ST_STRB: begin
					// held here while stalled, picks up again on the next free edge
					if (!stall) begin
						state_d = EBM_ST_END;
						if (!cur_q.write) begin
							rdata_d = data_s_q;
						end
						pins_d.write_strobe_n = 1'b1;
						if (mode_q == EBM_MODE_SEP) begin
							pins_d.read_strobe_n = 1'b1;
						end
					end
				end
				EBM_ST_END: begin
					state_d = EBM_ST_IDLE;
					pins_d.chip_select_n = '1;
					pins_d.read_strobe_n = 1'b1;
					pins_d.bus_data_oe = 1'b0;
					rsp_d = 1'b1;
					rdy_d = 1'b1;
				end
				default: begin
					state_d = EBM_ST_IDLE;
					pins_d  = PINS_IDLE;
				end
			endcase
		end
		if (!strap_done_q) begin
			rdy_d = strap_done_d;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_q <= EBM_ST_IDLE;
			cur_q   <= '0;
			mode_q  <= EBM_MODE_SEP;
			pend_q  <= 1'b0;
			rdy_q   <= 1'b0;
			rsp_q   <= 1'b0;
			rdata_q <= '0;
			pins_q  <= PINS_IDLE;
		end else begin
			state_q <= state_d;
			cur_q   <= cur_d;
			mode_q  <= mode_d;
			pend_q  <= pend_d;
			rdy_q   <= rdy_d;
			rsp_q   <= rsp_d;
			rdata_q <= rdata_d;
			pins_q  <= pins_d;
		end
	end

	assign req_ready_o = rdy_q;
	assign rsp_valid_o = rsp_q;
	assign rsp_rdata_o = rdata_q;
	assign pins_o      = pins_q;

endmodule

// file: dv/ebm_asserts.sv
/* checker for the bus master: pin timing, strobes, stalls.
   assumes a bind onto ebm_master and mode settings changed only while the bus is idle. */
module ebm_asserts
	import ebm_pkg::*;
(
	input wire logic                clk_i,             // core clock
	input wire logic                rst_b_i,           // reset, low
	input wire logic                bus_clock_in_i,    // bus clock
	input wire logic                wait_in_n_i,       // wait
	input wire logic [RDY_NUM-1:0]  host_port_ready_i, // ready
	input wire logic [2*CS_NUM-1:0] cs_mode_i,         // modes
	input wire logic [RDY_NUM-1:0]  ready_high_i,      // polarity
	input wire logic                req_valid_i,       // request
	input wire ebm_req_s            req_i,             // body
	input wire logic                req_ready_o,       // ready
	input wire logic                rsp_valid_o,       // done
	input wire ebm_pins_s           pins_o             // pins
);
	timeunit 1ns;
	timeprecision 1ps;
	ebm_req_s   h_q;
	logic [1:0] m;
	logic       host, sep, act, ok, bp_q;
	logic [6:0] bc_q, ws_q, rs_q;
	// mode of the running access
	assign m = cs_mode_i[2*h_q.cs+:2];
	assign host = m == 2'h2 && h_q.cs[2];
	assign sep = !host && m != 2'h1;
	assign act = pins_o.chip_select_n != 8'hff;
	assign ok = host_port_ready_i[h_q.cs[1:0]] ~^ ready_high_i[h_q.cs[1:0]];
	// -------------------------------------------
	// taken request, bus edge age, stall lengths
	// -------------------------------------------
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			h_q <= '0;
			bp_q <= 1'b0;
			bc_q <= 7'h0;
			ws_q <= 7'h0;
			rs_q <= 7'h0;
		end else begin
			if (req_valid_i && req_ready_o) h_q <= req_i;
			bp_q <= bus_clock_in_i;
			bc_q <= bus_clock_in_i && !bp_q ? 7'h0 : bc_q + 7'(bc_q != 7'h7f);
			ws_q <= act && !host && !wait_in_n_i ? ws_q + 7'(ws_q != 7'h7f) : 7'h0;
			rs_q <= act && host && !ok ? rs_q + 7'(rs_q != 7'h7f) : 7'h0;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	chk_pin_edge: assert property ($changed({pins_o.chip_select_n, pins_o.write_strobe_n,
		pins_o.read_strobe_n, pins_o.address_latch_strobe}) |-> bc_q inside {[1:6]}) else $error("pin off bus edge");
	chk_ale_addr: assert property (pins_o.address_latch_strobe |-> act && pins_o.bus_address_oe &&
		pins_o.bus_address == h_q.addr && pins_o.bus_data_oe && pins_o.bus_data == h_q.addr[15:0])
		else $error("address phase wrong");
	chk_cs_one: assert property (act |-> pins_o.chip_select_n == ~(8'h1 << h_q.cs))
		else $error("wrong chip select");
	chk_read_float: assert property (act && !pins_o.address_latch_strobe && !h_q.write |-> !pins_o.bus_data_oe)
		else $error("data driven on read");
	chk_write_data: assert property (act && !pins_o.address_latch_strobe && h_q.write |->
		pins_o.bus_data_oe && pins_o.bus_data == h_q.wdata) else $error("write data wrong");
	chk_sep_strobe: assert property (act && sep |-> (h_q.write ? pins_o.read_strobe_n : pins_o.write_strobe_n))
		else $error("wrong strobe");
	chk_rnw_level: assert property (act && !sep |-> pins_o.read_strobe_n == !h_q.write)
		else $error("direction wrong");
	chk_wait_halt: assert property (ws_q > 7'd24 |-> !rsp_valid_o) else $error("wait ignored");
	chk_ready_halt: assert property (rs_q > 7'd24 |-> !rsp_valid_o) else $error("ready ignored");
	chk_done_idle: assert property (rsp_valid_o |-> !act && !pins_o.bus_data_oe && req_ready_o)
		else $error("bus busy at done");
	cover property (rsp_valid_o && h_q.write);
	cover property (ws_q == 7'd30);
	cover property (rs_q == 7'd30);
endmodule

bind ebm_master ebm_asserts chk_u (.clk_i, .rst_b_i, .bus_clock_in_i, .wait_in_n_i, .host_port_ready_i,
	.cs_mode_i, .ready_high_i, .req_valid_i, .req_i, .req_ready_o, .rsp_valid_o, .pins_o);

// file: dv/ebm_periph.sv
/* peripheral model: one word per chip select, wait and ready stalls, straps.
   assumes the bench makes the bus clock. */
module ebm_periph
	import ebm_pkg::*;
#(
	parameter logic [ADDR_W-1:0] STRAP = 24'h5a3cf0 // board straps, arbitrary
)
(
	input wire logic                bus_clock_in_i,    // bus clock
	input wire ebm_pins_s           pins_i,            // master pins
	input wire logic [RDY_NUM-1:0]  ready_high_i,      // polarity
	input wire logic [3:0]          slow_i,            // stall edges
	input wire logic                stall_wait_i,      // stall by wait
	input wire logic                stall_rdy_i,       // stall by ready
	output logic                    wait_in_n_o,       // wait
	output logic [RDY_NUM-1:0]      host_port_ready_o, // ready
	output logic [ADDR_W-1:0]       bus_address_o,     // address wires
	output logic [DATA_W-1:0]       bus_data_o         // data wires
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [DATA_W-1:0] mem [CS_NUM];
	logic [DATA_W-1:0] last_q = 16'h0;
	logic [2:0]        sel;
	logic              act, stl;
	int                cnt = 0;
	// -----------------------------------
	// wires and stalls
	// -----------------------------------
	always_comb begin
		sel = 3'h0;
		for (int i = 0; i < CS_NUM; i++) if (!pins_i.chip_select_n[i]) sel = 3'(i);
	end
	assign act = pins_i.chip_select_n != 8'hff;
	assign stl = act && cnt < int'(slow_i);
	assign wait_in_n_o = !(stl && stall_wait_i);
	assign host_port_ready_o = {RDY_NUM{!(stl && stall_rdy_i)}} ~^ ready_high_i;
	assign bus_address_o = pins_i.bus_address_oe ? pins_i.bus_address : STRAP;
	// released data shows stored word in an access, else the inverse of the last
	assign bus_data_o = pins_i.bus_data_oe ? pins_i.bus_data : (act ? mem[sel] : ~last_q);
	always @(posedge bus_clock_in_i) begin
		cnt <= act ? cnt + 1 : 0;
		if (pins_i.bus_data_oe) last_q <= pins_i.bus_data;
	end
	// store on strobe release, only while the master drives data
	always @(posedge pins_i.write_strobe_n) if (act && pins_i.bus_data_oe) mem[sel] <= pins_i.bus_data;
endmodule

// file: dv/tb.sv
/* bench for the bus master: access on each chip select, stalls, straps.
   assumes the peripheral model and the bound checker. */
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ebm_pkg::*;
	localparam logic [ADDR_W-1:0] STRAP = 24'h5a3cf0;
	logic        clk_i = 0, rst_b_i = 0, bck = 0, req_valid_i = 0, sw = 0, sr = 0, ws_seen = 0;
	logic        wait_n, req_ready_o, rsp_valid_o, sv;
	logic [3:0]  slow = 4'h0, rdy;
	logic [23:0] aw, straps;
	logic [15:0] dw, rdata, modes = 16'h8924;
	logic [5:0]  tbl [7] = '{6'h22, 6'h26, 6'h16, 6'h35, 6'h3d, 6'h09, 6'h0d};
	ebm_req_s    req_i = '0;
	ebm_pins_s   pins;
	int          fails = 0, checks_done = 0, cyc;
	// core clock and a free bus clock
	always #2.5 clk_i = ~clk_i;
	initial #7 forever #32 bck = ~bck;
	ebm_master dut_u (.clk_i, .rst_b_i, .bus_clock_in_i(bck), .wait_in_n_i(wait_n), .host_port_ready_i(rdy),
		.bus_address_i(aw), .bus_data_i(dw), .cs_mode_i(modes), .ready_high_i(4'h9), .req_valid_i, .req_i,
		.req_ready_o, .rsp_valid_o, .rsp_rdata_o(rdata), .straps_o(straps), .straps_valid_o(sv), .pins_o(pins));
	ebm_periph #(.STRAP(STRAP)) far_u (.bus_clock_in_i(bck), .pins_i(pins), .ready_high_i(4'h9),
		.slow_i(slow), .stall_wait_i(sw), .stall_rdy_i(sr), .wait_in_n_o(wait_n), .host_port_ready_o(rdy),
		.bus_address_o(aw), .bus_data_o(dw));
	// ------------------------------
	// tasks
	// ------------------------------
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic test_done();
		if (fails == 0 && checks_done > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// one access; cyc counts cycles from take to done, ws_seen notes any write strobe pulse
	task automatic acc(input logic w, input logic [2:0] cs, input logic [15:0] d);
		int n;
		n = 0;
		@(negedge clk_i);
		while (!req_ready_o && n < 4000) begin
			@(negedge clk_i);
			n++;
		end
		req_i = '{write: w, cs: cs, addr: {cs, 5'h0, d}, wdata: d};
		req_valid_i = 1'b1;
		@(negedge clk_i);
		req_valid_i = 1'b0;
		ws_seen = 1'b0;
		cyc = 0;
		while (!rsp_valid_o && cyc < 4000) begin
			@(negedge clk_i);
			cyc++;
			if (!pins.write_strobe_n) ws_seen = 1'b1;
		end
		chk(24'(n >= 4000 || cyc >= 4000), 24'h0);
	endtask
	// reset, straps, each chip select, then the stall table
	initial begin
		repeat (20) @(negedge clk_i);
		chk(24'(pins.chip_select_n), 24'hff);
		chk(24'({pins.write_strobe_n, pins.read_strobe_n, pins.bus_data_oe, req_ready_o, sv}), 24'h18);
		rst_b_i = 1'b1;
		repeat (8) @(negedge clk_i);
		chk(24'(sv), 24'h1);
		chk(straps, STRAP);
		for (int c = 0; c < 8; c++) acc(1'b1, 3'(c), 16'ha50 + 16'(c));
		for (int c = 0; c < 8; c++) begin
			acc(1'b0, 3'(c), 16'h0);
			chk(24'(rdata), 24'ha50 + 24'(c));
			chk(24'(ws_seen), 24'(c == 1 || c > 3 && c != 6));
		end
		// every chip select but 2 moved to another mode, 2 stays sep under code 3: ds, sep, code 3, ds, host, ds, host, sep
		modes = 16'h2671;
		for (int c = 0; c < 8; c++) begin
			acc(1'b1, 3'(c), 16'h5a0 + 16'(c));
			acc(1'b0, 3'(c), 16'h0);
			chk(24'(rdata), 24'h5a0 + 24'(c));
			chk(24'(ws_seen), 24'(c != 1 && c != 2 && c != 7));
		end
		modes = 16'h8924;
		slow = 4'h6;
		for (int i = 0; i < 7; i++) begin
			{sw, sr} = tbl[i][1:0];
			acc(1'b1, tbl[i][4:2], 16'h0);
			chk(24'(cyc > 72), 24'(tbl[i][5]));
		end
		test_done();
	end
	// watchdog
	initial begin
		#60000;
		fails++;
		test_done();
	end
endmodule
